// ==== rtl/rlc_top.sv ====
// Purpose: Range limit checker with five-state machine and register file
// Assumes: Value, bounds, run enable and acknowledge come from logic on the same clock
// Notes:   Evaluation happens only on the cycle strobe of the owning group
`default_nettype none

// Behaviour
// [RL1] A value between the bounds inclusive gives state 1 with only within_range high.
// [RL2] A value outside the bounds gives state 3 with under_lower and over_upper showing which side.
// [RL3] With block_run_enable low the block is in state 2 and all four outputs are low.
// [RL4] A detected error gives state 4, error high, range outputs low, and a diagnostic message out.
// [RL5] A lower bound above the upper bound is an error with diagnostic 1 and message id 0x4090.
// [RL6] After an error, with no error pending and error_acknowledge high, the block goes to state 5.
// [RL7] Bounds come from the bound inputs when enabled, otherwise from the parameter registers.
// [RL8] Value and bounds may be signed or unsigned, 16 or 32 bits wide.
// [RL9] Two options separately expose the state code and diagnostic code in the process image.
// [RL10] Evaluation occurs once per logic cycle and the error state holds until the reset condition; block_run_enable low also leaves it for state 2.
// [RL11] All comparisons use the selected signedness and width.
module rlc_top
  import rlc_pkg::*;
#(
  parameter logic [15:0] BLOCK_NUMBER = 16'h0001
)
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic [ADDR_W-1:0]     avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [DATA_W-1:0]     avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [DATA_W-1:0]          avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  cycle_strobe,
  input  wire logic                  block_run_enable,
  input  wire logic                  error_acknowledge,
  input  wire logic [DATA_W-1:0]     analog_value_in,
  input  wire logic [DATA_W-1:0]     lower_bound_in,
  input  wire logic [DATA_W-1:0]     upper_bound_in,
  output logic                       error,
  output logic                       within_range,
  output logic                       under_lower,
  output logic                       over_upper,
  output logic [7:0]                 state_image,
  output logic [7:0]                 diag_image,
  output rlc_pkg::rlc_diag_msg_type  diag_msg,
  output logic                       diag_msg_valid,
  output logic                       irq
);

  import rlc_pkg::*;

  rlc_regs_type      r;
  rlc_regs_type      n;
  rlc_format_type    fmt;
  logic [DATA_W-1:0] lower_eff;
  logic [DATA_W-1:0] upper_eff;
  logic              cmp_below;
  logic              cmp_above;
  logic              cmp_inverted;

  // Byte-lane merge shared by the control and bound registers; the interrupt mask is written from lane 0 directly
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [3:0]        be);
    logic [DATA_W-1:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Output set of each state code
  function automatic rlc_outputs_type outs_of(input rlc_state_code_type s,
                                              input logic b,
                                              input logic a);
    rlc_outputs_type o;
    o = '0;
    unique case (s)
      ST_RUN:   o.within_range = 1'b1;  // [RL1]
      ST_SAFE:
      begin
        o.under_lower = b;              // [RL2]
        o.over_upper  = a;
      end
      ST_ERROR: o.error = 1'b1;         // [RL4]
      ST_STOP:  o = '0;                 // [RL3]
      ST_RESET: o = '0;                 // [RL6]
      default:  o = '0;
    endcase
    return o;
  endfunction

  // Priority of the state machine for one logic cycle
  function automatic rlc_state_code_type next_state(input rlc_state_code_type s,
                                                    input logic               run,
                                                    input logic               inv,
                                                    input logic               outside,
                                                    input logic               ack);
    rlc_state_code_type t;
    t = s;
    // Run low wins over everything, a pending error included
    if (!run)
    begin
      t = ST_STOP;                                         // [RL3]
    end
    else
    begin
      unique case (s)
        ST_ERROR:
        begin
          // Valid bounds alone do not leave the error state
          if (!inv && ack)
          begin
            t = ST_RESET;                                  // [RL6] [RL10]
          end
        end
        ST_RUN, ST_STOP, ST_SAFE, ST_RESET:
        begin
          if (inv)
          begin
            t = ST_ERROR;                                  // [RL4] [RL5]
          end
          else if (outside)
          begin
            t = ST_SAFE;                                   // [RL2]
          end
          else
          begin
            t = ST_RUN;                                    // [RL1]
          end
        end
        default: t = ST_STOP;
      endcase
    end
    return t;
  endfunction

  // Interrupt events raised by a state change
  function automatic logic [IRQ_W-1:0] events_of(input rlc_state_code_type cur,
                                                  input rlc_state_code_type nxt);
    logic [IRQ_W-1:0] e;
    e = '0;
    // Counted on entry only, so a value that stays out of range raises one event
    e[IRQ_ERROR] = (nxt == ST_ERROR) && (cur != ST_ERROR);
    e[IRQ_SAFE]  = (nxt == ST_SAFE) && (cur != ST_SAFE);
    e[IRQ_RESET] = (nxt == ST_RESET);
    return e;
  endfunction

  // Diagnostic message for inverted bounds
  function automatic rlc_diag_msg_type message_of(input logic [DATA_W-1:0] lo,
                                                  input logic [DATA_W-1:0] hi);
    rlc_diag_msg_type m;
    // Bounds are reported raw, right aligned as they were compared
    m.text_id  = MSG_INVERTED;
    m.block_no = BLOCK_NUMBER;
    m.param2   = lo;
    m.param3   = hi;
    return m;
  endfunction

  // Read view of every register; unmapped addresses read as zero
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a,
                                                  input rlc_regs_type      s);
    logic [DATA_W-1:0] w;
    w = '0;
    unique case (a)
      OFS_CTRL:     w = {{(DATA_W-CTRL_W){1'b0}}, s.ctrl};
      OFS_LOWER:    w = s.lower_par;
      OFS_UPPER:    w = s.upper_par;
      // Status packs state, diagnostic and outputs into one word
      OFS_STATUS:
      begin
        w[STAT_CODE_LSB +: 3] = s.state;
        w[STAT_DIAG_LSB +: 8] = s.diag;
        w[STAT_OUT_LSB  +: 4] = s.outs;
      end
      OFS_IRQ_STAT: w = {{(DATA_W-IRQ_W){1'b0}}, s.irq_stat};
      OFS_IRQ_MASK: w = {{(DATA_W-IRQ_W){1'b0}}, s.irq_mask};
      OFS_MSG_ID:   w = {16'h0000, s.msg.text_id};
      OFS_MSG_P1:   w = {16'h0000, s.msg.block_no};
      OFS_MSG_P2:   w = s.msg.param2;
      OFS_MSG_P3:   w = s.msg.param3;
      default:      w = '0;
    endcase
    return w;
  endfunction

  // Register file update for one accepted write; read-only words ignore it
  function automatic rlc_regs_type write_reg(input rlc_regs_type      s,
                                             input logic [ADDR_W-1:0] a,
                                             input logic [DATA_W-1:0] wd,
                                             input logic [3:0]        be);
    rlc_regs_type t;
    t = s;
    unique case (a)
      OFS_CTRL:
      begin
        t.ctrl = CTRL_W'(merge({{(DATA_W-CTRL_W){1'b0}}, s.ctrl}, wd, be));
      end
      OFS_LOWER:    t.lower_par = merge(s.lower_par, wd, be);
      OFS_UPPER:    t.upper_par = merge(s.upper_par, wd, be);
      // The mask is three bits wide, so only lane 0 matters
      OFS_IRQ_MASK:
      begin
        if (be[0])
        begin
          t.irq_mask = wd[IRQ_W-1:0];
        end
      end
      default:      t.irq_mask = s.irq_mask;
    endcase
    return t;
  endfunction

  // Process image byte: the code when exposed, zero otherwise
  function automatic logic [7:0] image_of(input logic       expose,
                                          input logic [7:0] code);
    return expose ? code : 8'h00;
  endfunction

  // Bounds are picked ahead of the compare so the message carries the pair in use
  assign fmt       = rlc_format_type'(r.ctrl[CTRL_FMT_LSB +: 2]);
  assign lower_eff = r.ctrl[CTRL_SRC_BIT] ? lower_bound_in : r.lower_par; // [RL7]
  assign upper_eff = r.ctrl[CTRL_SRC_BIT] ? upper_bound_in : r.upper_par; // [RL7]

  rlc_compare #(
    .W        (DATA_W)
  ) u_compare (
    .format   (fmt),
    .value    (analog_value_in),
    .lower    (lower_eff),
    .upper    (upper_eff),
    .below    (cmp_below),
    .above    (cmp_above),
    .inverted (cmp_inverted)
  );

  always_comb
  begin
    logic               req;
    logic               accept;
    logic [DATA_W-1:0]  rd;
    logic [IRQ_W-1:0]   ev;
    rlc_state_code_type ns;
    req       = avs_read | avs_write;
    accept    = req & ~r.waitrequest;
    rd        = '0;
    ev        = '0;
    ns        = r.state;
    n         = r;
    n.msg_valid = 1'b0;

    // One wait state: the request is seen, then accepted at the next edge
    n.waitrequest = ~(req & r.waitrequest);

    rd = read_word(avs_address, r);
    // Read data is captured in the wait state so it stands at the acceptance edge
    if (avs_read && r.waitrequest)
    begin
      n.readdata = rd;
    end

    if (avs_write && accept)
    begin
      n = write_reg(n, avs_address, avs_writedata, avs_byteenable);
    end

    // Reading the interrupt status clears only the bits it returned: an event
    // latched during the wait state stays pending for the next read, and one
    // of the clearing cycle itself survives because the set below wins
    if (avs_read && accept && avs_address == OFS_IRQ_STAT)
    begin
      n.irq_stat = r.irq_stat & ~r.readdata[IRQ_W-1:0];
    end

    if (cycle_strobe)                                      // [RL10]
    begin
      ns = next_state(r.state, block_run_enable, cmp_inverted, cmp_below | cmp_above, error_acknowledge);
      if (ns == ST_ERROR && r.state != ST_ERROR)
      begin
        n.diag      = DIAG_INVERTED;                       // [RL5]
        n.msg       = message_of(lower_eff, upper_eff);    // [RL5]
        n.msg_valid = 1'b1;                                // [RL4]
      end
      if (ns == ST_RESET || ns == ST_STOP)
      begin
        n.diag = DIAG_NONE;
      end
      ev      = events_of(r.state, ns);
      n.state = ns;
      // Outputs follow the state entered, never the one left
      n.outs  = outs_of(ns, cmp_below, cmp_above);
    end

    n.irq_stat  = n.irq_stat | ev;
    n.irq       = |(n.irq_stat & n.irq_mask);
    // Unexposed codes read as zero in the process image
    n.state_img = image_of(n.ctrl[CTRL_XST_BIT], {5'h00, n.state}); // [RL9]
    n.diag_img  = image_of(n.ctrl[CTRL_XDG_BIT], n.diag);            // [RL9]
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      // Fields not named below reset to zero
      r             <= '0;
      r.ctrl        <= CTRL_RESET;
      r.lower_par   <= LOWER_RESET;
      r.upper_par   <= UPPER_RESET;
      r.irq_mask    <= IRQ_MASK_RESET;
      r.state       <= ST_STOP;
      r.diag        <= DIAG_NONE;
      r.waitrequest <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign avs_readdata    = r.readdata;
  assign avs_waitrequest = r.waitrequest;
  assign error           = r.outs.error;
  assign within_range    = r.outs.within_range;
  assign under_lower     = r.outs.under_lower;
  assign over_upper      = r.outs.over_upper;
  assign state_image     = r.state_img;
  assign diag_image      = r.diag_img;
  assign diag_msg        = r.msg;
  assign diag_msg_valid  = r.msg_valid;
  assign irq             = r.irq;

endmodule

`default_nettype wire

// ==== rtl/rlc_pkg.sv ====
// Purpose: Shared constants and types for the range limit checker
// Assumes: 32-bit Avalon-MM register bus with byte addresses
// Notes:   Offsets are byte addresses of aligned 32-bit words
`default_nettype none

package rlc_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_LOWER    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_UPPER    = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_MSG_ID   = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_MSG_P1   = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_MSG_P2   = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_MSG_P3   = 6'h24;

  // Control field layout
  localparam int CTRL_W       = 5;
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_XST_BIT = 3;
  localparam int CTRL_XDG_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // Status field layout
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_DIAG_LSB = 8;
  localparam int STAT_OUT_LSB  = 16;

  // Parameter bound reset values
  localparam logic [DATA_W-1:0] LOWER_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UPPER_RESET = 32'h0000_7fff;

  // Interrupt bits
  localparam int IRQ_W     = 3;
  localparam int IRQ_ERROR = 0;
  localparam int IRQ_SAFE  = 1;
  localparam int IRQ_RESET = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // Diagnostics
  localparam logic [7:0]  DIAG_NONE     = 8'h00;
  localparam logic [7:0]  DIAG_INVERTED = 8'h01;
  localparam logic [15:0] MSG_INVERTED  = 16'h4090;

  typedef enum logic [1:0] {
    FMT_INT16  = 2'b00,
    FMT_INT32  = 2'b01,
    FMT_UINT16 = 2'b10,
    FMT_UINT32 = 2'b11
  } rlc_format_type;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_STOP  = 3'b010,
    ST_SAFE  = 3'b011,
    ST_ERROR = 3'b100,
    ST_RESET = 3'b101
  } rlc_state_code_type;

  typedef struct packed {
    logic error;
    logic within_range;
    logic under_lower;
    logic over_upper;
  } rlc_outputs_type;

  typedef struct packed {
    logic [15:0]       text_id;
    logic [15:0]       block_no;
    logic [DATA_W-1:0] param2;
    logic [DATA_W-1:0] param3;
  } rlc_diag_msg_type;

  typedef struct packed {
    logic [CTRL_W-1:0]  ctrl;
    logic [DATA_W-1:0]  lower_par;
    logic [DATA_W-1:0]  upper_par;
    logic [IRQ_W-1:0]   irq_mask;
    logic [IRQ_W-1:0]   irq_stat;
    logic               irq;
    rlc_state_code_type state;
    logic [7:0]         diag;
    rlc_outputs_type    outs;
    logic [7:0]         state_img;
    logic [7:0]         diag_img;
    rlc_diag_msg_type   msg;
    logic               msg_valid;
    logic               waitrequest;
    logic [DATA_W-1:0]  readdata;
  } rlc_regs_type;

endpackage

`default_nettype wire

// ==== rtl/rlc_compare.sv ====
// Purpose: Window comparison of a value against two bounds
// Assumes: Operands arrive right aligned in 32-bit words
// Notes:   Purely combinational; the caller registers the results
`default_nettype none

module rlc_compare
  import rlc_pkg::*;
#(
  parameter int W = 32
)
(
  input  wire rlc_format_type format,
  input  wire logic [W-1:0]   value,
  input  wire logic [W-1:0]   lower,
  input  wire logic [W-1:0]   upper,
  output logic                below,
  output logic                above,
  output logic                inverted
);

  // One extra bit lets signed and unsigned words share one signed compare
  function automatic logic signed [W:0] widen(input logic [W-1:0] x, input rlc_format_type f);
    logic signed [W:0] y;
    y = '0;
    unique case (f)
      FMT_INT16:  y = {{(W-14){x[15]}}, x[14:0]};
      FMT_UINT16: y = {{(W-15){1'b0}}, x[15:0]} & {1'b0, {(W-16){1'b0}}, {16{1'b1}}};
      FMT_INT32:  y = {x[W-1], x};
      FMT_UINT32: y = {1'b0, x};
    endcase
    return y;
  endfunction

  logic signed [W:0] v_e;
  logic signed [W:0] lo_e;
  logic signed [W:0] hi_e;

  always_comb
  begin
    v_e      = widen(value, format); // [RL8] [RL11]
    lo_e     = widen(lower, format);
    hi_e     = widen(upper, format);
    below    = v_e < lo_e;            // [RL11]
    above    = v_e > hi_e;
    inverted = lo_e > hi_e;           // [RL5]
  end

endmodule

`default_nettype wire

// ==== sim/rlc_chk.sv ====
// Purpose: Concurrent checks on the range checker ports
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every rlc_top instance
`default_nettype none

module rlc_chk
  import rlc_pkg::*;
(
  input wire logic                      clock,
  input wire logic                      reset_n,
  input wire logic                      avs_read,
  input wire logic                      avs_write,
  input wire logic                      avs_waitrequest,
  input wire logic                      cycle_strobe,
  input wire logic                      block_run_enable,
  input wire logic                      error_acknowledge,
  input wire logic                      error,
  input wire logic                      within_range,
  input wire logic                      under_lower,
  input wire logic                      over_upper,
  input wire logic [7:0]                state_image,
  input wire logic [7:0]                diag_image,
  input wire rlc_pkg::rlc_diag_msg_type diag_msg,
  input wire logic                      diag_msg_valid,
  input wire logic                      irq
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [3:0] outs = {error, within_range, under_lower, over_upper};
  wire logic       req  = avs_read | avs_write;
  wire logic       acc  = req & ~avs_waitrequest;
  wire logic       hold = cycle_strobe & block_run_enable & ~error_acknowledge;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence one_wait_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence msg_pulse_s;
    (error && diag_msg.text_id == MSG_INVERTED) ##1 !diag_msg_valid;
  endsequence
  outs_exclusive_a: assert property ($onehot0(outs))
    else $error("more than one result output high");
  stop_clear_a: assert property (cycle_strobe && !block_run_enable |=> outs == 4'h0)
    else $error("outputs not cleared in stop");
  outs_hold_a: assert property (!cycle_strobe |=> $stable(outs))
    else $error("outputs changed without strobe");
  error_hold_a: assert property (error && hold |=> error)
    else $error("error left without acknowledge");
  msg_error_a: assert property (diag_msg_valid |-> msg_pulse_s)
    else $error("message pulse without error or wrong id");
  error_msg_a: assert property ($rose(error) |-> diag_msg_valid)
    else $error("error entered without message");
  one_wait_a: assert property ($rose(req) |-> one_wait_s)
    else $error("bus answer not after one wait state");
  irq_clear_a: assert property ($fell(irq) |-> $past(acc) || $past(acc, 2))
    else $error("interrupt fell without bus access");
  image_range_a: assert property (state_image <= 8'h05 && diag_image <= 8'h01)
    else $error("image code out of range");
endmodule

bind rlc_top rlc_chk u_chk (.clock, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .cycle_strobe,
  .block_run_enable, .error_acknowledge, .error, .within_range, .under_lower, .over_upper, .state_image,
  .diag_image, .diag_msg, .diag_msg_valid, .irq);

`default_nettype wire

// ==== sim/rlc_group.sv ====
// Purpose: Owning group control as seen by one range checker
// Assumes: Bench raises go for one cycle per logic cycle wanted
// Notes:   Levels are registered so they stay put around each strobe
`default_nettype none

module rlc_group
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic go,
  input  wire logic run_req,
  input  wire logic ack_req,
  output logic      cycle_strobe,
  output logic      block_run_enable,
  output logic      error_acknowledge
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clock)
  begin
    cycle_strobe      <= reset_n & go;
    block_run_enable  <= reset_n & run_req;
    error_acknowledge <= reset_n & ack_req;
  end
endmodule

`default_nettype wire

// ==== sim/rlc_tb.sv ====
// Purpose: Self-checking bench for the range limit checker
// Assumes: Group model supplies strobe, run and acknowledge
// Notes:   Parameter bounds are 0 and 0x7fff after reset
`default_nettype none

module rlc_tb;
  import rlc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clock = 0, reset_n = 0, rd = 0, wr = 0, go = 0, run = 1, ack = 0;
  logic [5:0]       adr = 0;
  logic [31:0]      wdat = 0, rdat, v = 0, lo = 0, hi = 0;
  int               err_count = 0, compares = 0;
  wire logic [31:0] readdata;
  wire logic [7:0]  simg, dimg;
  wire logic        wreq, strobe, fb_run, fb_ack, err, inr, und, ovr, msgv, irq;
  wire rlc_diag_msg_type msg;

  rlc_group grp (.clock, .reset_n, .go, .run_req(run), .ack_req(ack), .cycle_strobe(strobe),
    .block_run_enable(fb_run), .error_acknowledge(fb_ack));
  rlc_top dut (.clock, .reset_n, .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hf), .avs_readdata(readdata), .avs_waitrequest(wreq), .cycle_strobe(strobe),
    .block_run_enable(fb_run), .error_acknowledge(fb_ack), .analog_value_in(v), .lower_bound_in(lo),
    .upper_bound_in(hi), .error(err), .within_range(inr), .under_lower(und), .over_upper(ovr),
    .state_image(simg), .diag_image(dimg), .diag_msg(msg), .diag_msg_valid(msgv), .irq);

  initial
    forever #50 clock = ~clock;

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    rdat = readdata;
    rd <= 0;
    wr <= 0;
    check(32'(n < 50), 32'h1);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(0, a, 0);
    check(rdat, exp);
  endtask

  // One logic cycle; results are settled when it returns
  task automatic eval(input logic [31:0] val, l, h, input logic r, k);
    @(posedge clock);
    go <= 1;
    v <= val;
    lo <= l;
    hi <= h;
    run <= r;
    ack <= k;
    @(posedge clock);
    go <= 0;
    @(posedge clock);
    #1;
  endtask

  task automatic outs(input logic [3:0] e);
    check(32'({err, inr, und, ovr}), 32'(e));
  endtask

  task automatic t_regs();
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_LOWER, 32'h0);
    rchk(OFS_UPPER, 32'h7fff);
    rchk(OFS_IRQ_MASK, 32'h0);
    rchk(6'h3c, 32'h0);
  endtask

  task automatic t_formats();
    for (int f = 0; f < 4; f++)
    begin
      bus(1, OFS_CTRL, 32'(f));
      eval(32'h0000_8000, 0, 0, 1, 0);
      outs(f == 0 ? 4'h2 : 4'h1);
      eval(32'hffff_ffff, 0, 0, 1, 0);
      outs(f > 1 ? 4'h1 : 4'h2);
      eval(32'h0001_0005, 0, 0, 1, 0);
      outs(f[0] ? 4'h1 : 4'h4);
      eval(32'h0000_7fff, 0, 0, 1, 0);
      outs(4'h4);
    end
  endtask

  task automatic t_inputs();
    bus(1, OFS_CTRL, 32'h05);
    eval(-32'sd11, -32'sd10, 32'd10, 1, 0);
    outs(4'h2);
    eval(-32'sd10, -32'sd10, 32'd10, 1, 0);
    outs(4'h4);
    eval(32'd11, -32'sd10, 32'd10, 1, 0);
    outs(4'h1);
    eval(32'd5, 32'd5, 32'd5, 0, 0);
    outs(4'h0);
    rchk(OFS_STATUS, 32'h2);
  endtask

  task automatic t_error();
    bus(1, OFS_CTRL, 32'h1d);
    rchk(OFS_IRQ_STAT, 32'h2);
    eval(0, 32'd5, 32'd4, 1, 0);
    outs(4'h8);
    check(32'(msgv), 32'h1);
    check(32'({simg, dimg}), 32'h0401);
    check(msg[95:64], 32'h4090_0001);
    check(msg[63:32], 32'd5);
    check(msg[31:0], 32'd4);
    rchk(OFS_STATUS, 32'h0008_0104);
    check(32'(irq), 32'h0);
    bus(1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock);
    #1;
    check(32'(irq), 32'h1);
    rchk(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clock);
    #1;
    check(32'(irq), 32'h0);
    eval(0, 32'd5, 32'd4, 1, 1);
    outs(4'h8);
    eval(0, -32'sd1, 32'd1, 1, 0);
    outs(4'h8);
    eval(0, -32'sd1, 32'd1, 1, 1);
    outs(4'h0);
    check(32'({simg, dimg}), 32'h0500);
    rchk(OFS_IRQ_STAT, 32'h4);
    eval(0, -32'sd1, 32'd1, 1, 0);
    outs(4'h4);
    bus(1, OFS_CTRL, 32'h05);
    eval(0, -32'sd1, 32'd1, 1, 0);
    check(32'({simg, dimg}), 32'h0);
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    reset_n <= 1;
    t_regs();
    t_formats();
    t_inputs();
    t_error();
    complete_run();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    err_count++;
    complete_run();
  end
endmodule

`default_nettype wire
